// [rtl/cca_assess.sv]
// Clear channel assessment state machine with APB register access
// Operation
// - Indicator pin continuous, polarity set by bit
// - Bypass makes the channel always clear
// - Energy flag when strength exceeds threshold
// - Carrier flag when sync amplitude meets threshold
// - Flag edges and time-out trigger decisions
// - Carrier sense active means busy
// - Carrier sense restarts the time-out counters
// - Both flags inactive means clear
// - Energy only counts and stays busy below N
// - Count reaching N resets and declares clear
// - Time-out spans M times N from settings
// - Indicator is advisory, drives no radio operation
// - Instantaneous signal strength readable in status
// - Amplitude threshold drives carrier; phase threshold is only reported in status
`timescale 1ns/100ps
`include "cca_cfg.svh"
module cca_assess
    import cca_pkg::*;
#(
    parameter int RSSI_W = 6,
    parameter int CNT_W  = 8,
    parameter int SQ_W   = 16
)(
    // Clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Signal strength samples from the converter
    input  wire logic              rssiValid,
    input  wire logic [RSSI_W-1:0] rssiValue,
    // Dwell quality measures from the acquisition logic
    input  wire logic              dwellValid,
    input  wire logic [SQ_W-1:0]   syncAmplitudeQuality,
    input  wire logic [SQ_W-1:0]   phaseNoise,
    // Outputs
    output logic                   ccaPin,
    output logic                   irq
);

    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    logic                bypass_r;
    logic                polarity_r;
    logic [RSSI_W-1:0]   rssiThr_r;
    logic [CNT_W-1:0]    innerM_r;
    logic [CNT_W-1:0]    outerN_r;
    logic [SQ_W-1:0]     ampThr_r;
    logic [SQ_W-1:0]     phaseThr_r;
    logic [RSSI_W-1:0]   rssi_r;
    logic                phaseOk_r;
    cca_flags_type       flags_r;
    cca_flags_type       prev_r;
    cca_state_type       state_r;
    cca_state_type       state_nxt;
    logic                busy_r;
    logic                busy_nxt;
    logic                pin_r;
    cca_events_type      irqStat_r;
    cca_events_type      irqMask_r;
    cca_events_type      events;
    logic                irq_r;
    logic [31:0]         prdata_r;
    logic                pready_r;
    logic                pslverr_r;
    logic                expire;
    logic [CNT_W-1:0]    outerCount;
    logic                trigger;
    logic                apbAccess;
    logic                apbWrite;
    logic                apbRead;
    logic                mapped;
    logic [31:0]         rdMux;

    // Reset word of the control register, kept whole so bits can be picked
    localparam logic [31:0] RST_CTRL = `CCA_RST_CTRL;

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // One wait state so that read data can come straight from a flop
    assign apbAccess = psel && penable && pready_r;
    assign apbWrite  = apbAccess && pwrite;
    assign apbRead   = apbAccess && !pwrite;

    // Address decode and read mux; unmapped reads return zero
    always_comb
    begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        case (paddr)
            `CCA_OFF_CTRL:
            begin
                rdMux[`CCA_CTRL_BYPASS]   = bypass_r;
                rdMux[`CCA_CTRL_POLARITY] = polarity_r;
            end
            `CCA_OFF_RSSI_THR:  rdMux[RSSI_W-1:0] = rssiThr_r;
            `CCA_OFF_INNER_M:   rdMux[CNT_W-1:0]  = innerM_r;
            `CCA_OFF_OUTER_N:   rdMux[CNT_W-1:0]  = outerN_r;
            `CCA_OFF_AMP_THR:   rdMux[SQ_W-1:0]   = ampThr_r;
            `CCA_OFF_PHASE_THR: rdMux[SQ_W-1:0]   = phaseThr_r;
            `CCA_OFF_STATUS:
            begin
                rdMux[RSSI_W-1:0]       = rssi_r;
                rdMux[`CCA_ST_ED]       = flags_r.energy;
                rdMux[`CCA_ST_CS]       = flags_r.carrier;
                rdMux[`CCA_ST_BUSY]     = busy_r;
                rdMux[`CCA_ST_PHASE_OK] = phaseOk_r;
                rdMux[`CCA_ST_STATE_LSB +: 3] = state_r;
            end
            `CCA_OFF_IRQ_STAT:  rdMux[3:0] = irqStat_r;
            `CCA_OFF_IRQ_MASK:  rdMux[3:0] = irqMask_r;
            default:            mapped = 1'b0;
        endcase
    end

    // Handshake: ready rises after the first access cycle, falls after
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
            if (psel && penable && !pready_r && !pwrite)
                prdata_r <= rdMux;
        end
    end

    // Writable settings
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bypass_r   <= RST_CTRL[`CCA_CTRL_BYPASS];
            polarity_r <= RST_CTRL[`CCA_CTRL_POLARITY];
            rssiThr_r  <= RSSI_W'(`CCA_RST_RSSI_THR);
            innerM_r   <= CNT_W'(`CCA_RST_INNER_M);
            outerN_r   <= CNT_W'(`CCA_RST_OUTER_N);
            ampThr_r   <= SQ_W'(`CCA_RST_AMP_THR);
            phaseThr_r <= SQ_W'(`CCA_RST_PHASE_THR);
            irqMask_r  <= `CCA_RST_IRQ_MASK;
        end
        else if (ce && apbWrite)
        begin
            case (paddr)
                `CCA_OFF_CTRL:
                begin
                    bypass_r   <= pwdata[`CCA_CTRL_BYPASS];
                    polarity_r <= pwdata[`CCA_CTRL_POLARITY];
                end
                `CCA_OFF_RSSI_THR:  rssiThr_r  <= pwdata[RSSI_W-1:0];
                `CCA_OFF_INNER_M:   innerM_r   <= pwdata[CNT_W-1:0];
                `CCA_OFF_OUTER_N:   outerN_r   <= pwdata[CNT_W-1:0];
                `CCA_OFF_AMP_THR:   ampThr_r   <= pwdata[SQ_W-1:0];
                `CCA_OFF_PHASE_THR: phaseThr_r <= pwdata[SQ_W-1:0];
                `CCA_OFF_IRQ_MASK:  irqMask_r  <= pwdata[3:0];
                default:            ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Channel measures
    // ---------------------------------------------------------------
    // Latest strength sample and its threshold comparison
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rssi_r         <= '0;
            flags_r.energy <= 1'b0;
        end
        else if (ce && rssiValid)
        begin
            rssi_r         <= rssiValue;
            flags_r.energy <= rssiValue > rssiThr_r;
        end
    end

    // Dwell result: amplitude decides carrier sense, phase is reported
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            flags_r.carrier <= 1'b0;
            phaseOk_r       <= 1'b0;
        end
        else if (ce && dwellValid)
        begin
            flags_r.carrier <= syncAmplitudeQuality >= ampThr_r;
            phaseOk_r       <= phaseNoise <= phaseThr_r;
        end
    end

    // Previous flags for change detection
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            prev_r <= '0;
        else if (ce)
            prev_r <= flags_r;
    end

    // A decision is taken only on a flag edge or a time-out
    assign trigger = (flags_r != prev_r) || expire;

    // ---------------------------------------------------------------
    // Watchdog time-out
    // ---------------------------------------------------------------
    // Runs only while energy alone is seen; carrier sense restarts it
    cca_timeout #(
        .CNT_W      (CNT_W)
    ) u_timeout (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .ce         (ce),
        .run        (state_r == ST_ENERGY),
        .restart    (flags_r.carrier),
        .innerLimit (innerM_r),
        .outerLimit (outerN_r),
        .expire     (expire),
        .outerCount (outerCount)
    );

    // ---------------------------------------------------------------
    // Assessment state machine
    // ---------------------------------------------------------------
    // Next state; holds between triggers
    always_comb
    begin
        state_nxt = state_r;
        if (trigger)
        begin
            case ({flags_r.carrier, flags_r.energy})
                2'b11:   state_nxt = ST_BOTH;
                2'b10:   state_nxt = ST_CARRIER;
                2'b01:
                begin
                    if (expire && state_r == ST_ENERGY)
                        state_nxt = ST_TIMEDOUT;
                    else if (state_r != ST_TIMEDOUT || expire == 1'b0)
                        state_nxt = ST_ENERGY;
                end
                2'b00:   state_nxt = ST_CLEAR;
                default: state_nxt = ST_CLEAR;
            endcase
        end
    end

    // Busy decode; bypass forces a clear indication at all times
    always_comb
    begin
        case (state_nxt)
            ST_CARRIER: busy_nxt = 1'b1;
            ST_BOTH:    busy_nxt = 1'b1;
            ST_ENERGY:  busy_nxt = 1'b1;
            default:    busy_nxt = 1'b0;
        endcase
        if (bypass_r)
            busy_nxt = 1'b0;
    end

    // State and indicator; the pin only advises the processor, it gates
    // nothing in the radio, which may transmit whatever it shows
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= ST_CLEAR;
            busy_r  <= 1'b0;
            pin_r   <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            busy_r  <= busy_nxt;
            pin_r   <= polarity_r ? !busy_nxt : busy_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    assign events.toBusy   = busy_nxt && !busy_r;
    assign events.toClear  = !busy_nxt && busy_r;
    assign events.timeout  = expire;
    assign events.csChange = flags_r.carrier != prev_r.carrier;

    // Sticky status, cleared by a read; a new event wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irqStat_r <= '0;
            irq_r     <= 1'b0;
        end
        else if (ce)
        begin
            if (apbRead && paddr == `CCA_OFF_IRQ_STAT)
                // Clear only what the read returned; later events survive
                irqStat_r <= cca_events_type'((irqStat_r & ~prdata_r[3:0])
                                              | events);
            else
                irqStat_r <= irqStat_r | events;
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign ccaPin  = pin_r;
    assign irq     = irq_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_pin_polarity: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce |=> (ccaPin == ($past(polarity_r) ? !busy_r : busy_r)))
        else $error("indicator level disagrees with polarity");

    a_bypass_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && bypass_r) |=> !busy_r)
        else $error("busy shown while bypassed");

    a_energy_thresh: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && rssiValid) |=>
            (flags_r.energy == ($past(rssiValue) > $past(rssiThr_r))))
        else $error("energy flag wrong for sample");

    a_carrier_thresh: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && dwellValid) |=> (flags_r.carrier ==
            ($past(syncAmplitudeQuality) >= $past(ampThr_r))))
        else $error("carrier flag wrong for dwell");

    a_carrier_busy: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && flags_r.carrier && !bypass_r) |=> busy_r)
        else $error("carrier sensed but channel not busy");

    a_idle_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && flags_r == '0 && prev_r != '0) |=> !busy_r)
        else $error("no flags but channel busy");

    a_energy_wait: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && state_r == ST_ENERGY && !expire && !bypass_r &&
         flags_r == 2'b10 && prev_r == flags_r) |=> busy_r)
        else $error("energy wait not busy");

    a_timeout_clear: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && expire && state_r == ST_ENERGY && flags_r == 2'b10)
            |=> (!busy_r && state_r == ST_TIMEDOUT))
        else $error("time-out did not declare clear");

endmodule

// [rtl/cca_cfg.svh]
// Register offsets, field positions and reset values of the channel assessor
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define CCA_OFF_CTRL      8'h00
`define CCA_OFF_RSSI_THR  8'h04
`define CCA_OFF_INNER_M   8'h08
`define CCA_OFF_OUTER_N   8'h0c
`define CCA_OFF_AMP_THR   8'h10
`define CCA_OFF_PHASE_THR 8'h14
`define CCA_OFF_STATUS    8'h18
`define CCA_OFF_IRQ_STAT  8'h1c
`define CCA_OFF_IRQ_MASK  8'h20

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CCA_CTRL_BYPASS   0
`define CCA_CTRL_POLARITY 5
`define CCA_ST_ED         8
`define CCA_ST_CS         9
`define CCA_ST_BUSY       10
`define CCA_ST_PHASE_OK   11
`define CCA_ST_STATE_LSB  12
`define CCA_IRQ_TO_BUSY   0
`define CCA_IRQ_TO_CLEAR  1
`define CCA_IRQ_TIMEOUT   2
`define CCA_IRQ_CS_CHANGE 3

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define CCA_RST_CTRL      32'h0000_0020
`define CCA_RST_RSSI_THR  8'h20
`define CCA_RST_INNER_M   8'hff
`define CCA_RST_OUTER_N   8'hff
`define CCA_RST_AMP_THR   16'h0100
`define CCA_RST_PHASE_THR 16'h0100
`define CCA_RST_IRQ_MASK  4'h0

`endif

// [rtl/cca_pkg.sv]
// Types shared by the channel assessor modules
package cca_pkg;

    // Assessment states
    typedef enum logic [2:0] {
        ST_CLEAR,
        ST_CARRIER,
        ST_BOTH,
        ST_ENERGY,
        ST_TIMEDOUT
    } cca_state_type;

    // Channel flags that travel together
    typedef struct packed {
        logic energy;
        logic carrier;
    } cca_flags_type;

    // Events that feed the interrupt status
    typedef struct packed {
        logic csChange;
        logic timeout;
        logic toClear;
        logic toBusy;
    } cca_events_type;

endpackage

// [rtl/cca_timeout.sv]
// Nested inner/outer watchdog count for energy-only interference
`timescale 1ns/100ps
`include "cca_cfg.svh"
module cca_timeout
    import cca_pkg::*;
#(
    parameter int CNT_W = 8
)(
    // Clock, reset, enable
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Control
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] innerLimit,
    input  wire logic [CNT_W-1:0] outerLimit,
    // Results
    output logic                  expire,
    output logic      [CNT_W-1:0] outerCount
);

    logic [CNT_W-1:0] inner_r;
    logic [CNT_W-1:0] outer_r;
    logic             expire_r;
    logic             innerWrap;
    logic             outerDone;

    // A limit of zero behaves as one so the count can never stall
    assign innerWrap = (inner_r + 1'b1) >= innerLimit;
    assign outerDone = (outer_r + 1'b1) >= outerLimit;

    // Inner count advances every clock while run is high and restart low, and wraps at M
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            inner_r <= '0;
        else if (ce)
        begin
            if (restart || !run)
                inner_r <= '0;
            else if (innerWrap)
                inner_r <= '0;
            else
                inner_r <= inner_r + 1'b1;
        end
    end

    // Outer count steps on each inner wrap; reaching N ends the wait
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            outer_r  <= '0;
            expire_r <= 1'b0;
        end
        else if (ce)
        begin
            expire_r <= 1'b0;
            if (restart || !run)
                outer_r <= '0;
            else if (innerWrap)
            begin
                if (outerDone)
                begin
                    outer_r  <= '0;
                    expire_r <= 1'b1;
                end
                else
                    outer_r <= outer_r + 1'b1;
            end
        end
    end

    assign expire     = expire_r;
    assign outerCount = outer_r;

    // Restart empties the outer count
    a_restart_clears: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && restart) |=> (outerCount == '0 && !expire))
        else $error("outer count not cleared on restart");

    // Each inner wrap below N advances the outer count by one
    a_outer_step: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ce && run && !restart && innerWrap && !outerDone)
            |=> (outer_r == $past(outer_r) + 1'b1))
        else $error("outer count did not step on inner wrap");

endmodule

// [verification/cca_proc_model.sv]
// Network processor model that watches the channel indicator pin
`timescale 1ns/100ps
module cca_proc_model
    import cca_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Indicator pin and how to read it
    input  wire logic ccaPin,
    input  wire logic polarity,
    input  wire logic ignoreCca,
    // Processor view
    output logic      chBusy,
    output logic      txGo
);
    // Pin decoded against the programmed polarity; high level means clear
    // when the polarity bit is set
    assign chBusy = polarity ? ~ccaPin : ccaPin;

    // Transmit permission; the indicator is only advice and may be ignored
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            txGo <= 1'b0;
        else
            txGo <= ignoreCca | ~chBusy;
    end
endmodule

// [verification/test_cca_assess.sv]
// Self-checking bench for the channel assessor
`timescale 1ns/100ps
`include "cca_cfg.svh"
module test_cca_assess
    import cca_pkg::*;
;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic        ref_clk;
    logic        rst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rssiValid;
    logic [5:0]  rssiValue;
    logic        dwellValid;
    logic [15:0] syncAmplitudeQuality;
    logic [15:0] phaseNoise;
    logic        ccaPin;
    logic        irq;
    logic        polarity;
    logic        chBusy;
    logic        txGo;
    logic        ignoreCca;
    logic        lastErr;
    logic [31:0] rd;
    int          n_mismatch;
    int          n_tests;
    int          cycles;
    int          n;

    localparam logic [7:0] REG_A [7] = '{`CCA_OFF_CTRL, `CCA_OFF_RSSI_THR,
        `CCA_OFF_INNER_M, `CCA_OFF_OUTER_N, `CCA_OFF_AMP_THR,
        `CCA_OFF_PHASE_THR, `CCA_OFF_IRQ_MASK};
    localparam logic [31:0] REG_V [7] = '{32'h20, 32'h20, 32'hff, 32'hff,
        32'h100, 32'h100, 32'h0};

    cca_assess u_cca_assess (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rssiValid(rssiValid), .rssiValue(rssiValue),
        .dwellValid(dwellValid),
        .syncAmplitudeQuality(syncAmplitudeQuality),
        .phaseNoise(phaseNoise), .ccaPin(ccaPin), .irq(irq));

    cca_proc_model u_cca_proc_model (.ref_clk(ref_clk), .rst(rst),
        .ccaPin(ccaPin), .polarity(polarity), .ignoreCca(ignoreCca),
        .chBusy(chBusy), .txGo(txGo));

    // -----------------------------------------------------------------
    // Clock and hang guard
    // -----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Whole run needs about two hundred cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Strength sample; value scrambled once the strobe drops
    task automatic rssi(input logic [5:0] v);
        @(posedge ref_clk);
        rssiValid <= 1'b1;
        rssiValue <= v;
        @(posedge ref_clk);
        rssiValid <= 1'b0;
        rssiValue <= ~v;
    endtask

    task automatic dwell(input logic [15:0] amp, input logic [15:0] ph);
        @(posedge ref_clk);
        dwellValid <= 1'b1;
        syncAmplitudeQuality <= amp;
        phaseNoise <= ph;
        @(posedge ref_clk);
        dwellValid <= 1'b0;
        syncAmplitudeQuality <= ~amp;
        phaseNoise <= ~ph;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // Cycles from the processor seeing busy until it sees clear;
    // the busy indication lags the sample, so wait for it first
    task automatic wait_clear(output int c);
        c = 0;
        while (chBusy !== 1'b1 && c < 8)
        begin
            @(posedge ref_clk);
            c++;
        end
        c = 0;
        while (chBusy !== 1'b0 && c < 300)
        begin
            @(posedge ref_clk);
            c++;
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial
    begin
        {rst, ce, polarity} = 3'b111;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rssiValid, rssiValue, dwellValid, ignoreCca} = '0;
        {syncAmplitudeQuality, phaseNoise} = '0;
        {cycles, n_mismatch, n_tests} = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        wait_cyc(3);
        chk(ccaPin, 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, REG_A[i], 32'h0);
            chk(rd, REG_V[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        $display("test reset done");

        // Long time-out so the energy state lasts through the reads
        apb(1'b1, `CCA_OFF_INNER_M, 32'h3);
        apb(1'b1, `CCA_OFF_OUTER_N, 32'h14);
        apb(1'b1, `CCA_OFF_IRQ_MASK, 32'h1);
        apb(1'b0, `CCA_OFF_IRQ_STAT, 32'h0);
        rssi(6'h20);
        wait_cyc(4);
        chk(chBusy, 1'b0);
        rssi(6'h30);
        wait_cyc(4);
        chk({chBusy, irq}, 2'b11);
        apb(1'b0, `CCA_OFF_STATUS, 32'h0);
        chk(rd & 32'h77ff, 32'h3530);
        apb(1'b0, `CCA_OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h1);
        wait_cyc(2);
        chk(irq, 1'b0);
        dwell(16'h0100, 16'h0080);
        wait_cyc(4);
        apb(1'b0, `CCA_OFF_STATUS, 32'h0);
        chk(rd & 32'h7fff, 32'h2f30);
        rssi(6'h10);
        wait_cyc(4);
        chk(chBusy, 1'b1);
        dwell(16'h00ff, 16'h0200);
        wait_cyc(4);
        chk(chBusy, 1'b0);
        apb(1'b0, `CCA_OFF_STATUS, 32'h0);
        chk(rd & 32'h7fff, 32'h0010);
        $display("test flags done");

        // Short watchdog: 3 by 2
        apb(1'b1, `CCA_OFF_OUTER_N, 32'h2);
        apb(1'b0, `CCA_OFF_IRQ_STAT, 32'h0);
        rssi(6'h30);
        wait_clear(n);
        chk(n >= 6 && n <= 8, 1'b1);
        wait_cyc(5);
        chk({chBusy, irq}, 2'b01);
        apb(1'b0, `CCA_OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h7);
        rssi(6'h10);
        apb(1'b1, `CCA_OFF_OUTER_N, 32'h4);
        rssi(6'h30);
        wait_cyc(8);
        dwell(16'h0200, 16'h0080);
        wait_cyc(3);
        dwell(16'h0000, 16'h0080);
        wait_clear(n);
        chk(n >= 12 && n <= 18, 1'b1);
        $display("test timeout done");

        // Bypass, then polarity
        rssi(6'h10);
        apb(1'b1, `CCA_OFF_OUTER_N, 32'h14);
        apb(1'b1, `CCA_OFF_CTRL, 32'h21);
        rssi(6'h30);
        wait_cyc(4);
        chk(chBusy, 1'b0);
        apb(1'b1, `CCA_OFF_CTRL, 32'h00);
        polarity <= 1'b0;
        wait_cyc(2);
        chk(ccaPin, 1'b1);
        chk(txGo, 1'b0);
        ignoreCca <= 1'b1;
        wait_cyc(2);
        chk(txGo, 1'b1);
        ignoreCca <= 1'b0;
        rssi(6'h10);
        wait_cyc(4);
        chk(ccaPin, 1'b0);
        $display("test pin done");

        // Enable low: a strong sample must not be taken nor reach the pin
        ce <= 1'b0;
        rssi(6'h30);
        wait_cyc(4);
        chk(ccaPin, 1'b0);
        ce <= 1'b1;
        wait_cyc(2);
        $display("test freeze done");
        end_of_test();
    end
endmodule
